/* hw/conv_pkg.sv */
package conv_pkg;
   // Register byte offsets
   localparam logic [5:0] CTRL_OFS = 6'h00;
   localparam logic [5:0] SRC0_OFS = 6'h04;
   localparam logic [5:0] SRC1_OFS = 6'h08;
   localparam logic [5:0] SRC2_OFS = 6'h0c;
   localparam logic [5:0] DSG_OFS = 6'h10;
   localparam logic [5:0] DEST_OFS = 6'h14;
   localparam logic [5:0] AREA_OFS = 6'h18;
   localparam logic [5:0] STAT_OFS = 6'h1c;
   localparam logic [5:0] RES0_OFS = 6'h20;
   localparam logic [5:0] RES1_OFS = 6'h24;
   // Control bits
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_OP_BIT = 1;
   localparam int CTRL_EXEC_BIT = 2;
   // Area and pointer check bits, supplied by the sequencer
   localparam int AREA_SRC_BIT = 0;
   localparam int AREA_RES_BIT = 1;
   localparam int AREA_PTR_BIT = 2;
   // Status bits
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_ERR_BIT = 2;
   localparam int STAT_ZERO_BIT = 3;
   // Reset values
   localparam logic [15:0] WORD_RST = 16'h0000;
   // Time conversion constants
   localparam logic [12:0] SEC_PER_HOUR = 13'h0e10;
   localparam logic [25:0] SEC_LIMIT = 26'h225_50ff;
   localparam logic [13:0] DEC_SCALE = 14'h2710;
   localparam logic [11:0] SEC_PER_MIN = 12'h03c;
   localparam logic [4:0] DIV_LAST = 5'h19;
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam logic [7:0] MINSEC_MAX = 8'h59;
   // Digit designator encodings
   localparam logic [3:0] DSG_POS_MAX = 4'h3;
   localparam logic [3:0] DSG_HALF_MAX = 4'h1;
   localparam logic [3:0] PAR_NONE = 4'h0;
   localparam logic [3:0] PAR_EVEN = 4'h1;
   localparam logic [3:0] PAR_ODD = 4'h2;
   // ASCII ranges of hexadecimal digits
   localparam logic [6:0] ASC_0 = 7'h30;
   localparam logic [6:0] ASC_9 = 7'h39;
   localparam logic [6:0] ASC_A = 7'h41;
   localparam logic [6:0] ASC_F = 7'h46;
   localparam logic [3:0] HEX_A = 4'ha;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_DIV = 3'h2,
      ST_FIN = 3'h4
   } conv_state_t;
endpackage

/* hw/time_ascii_conv.sv */
// Behaviour
// - Seconds in S,S+1 become time in R,R+1
// - Seconds bits 0-7, minutes 8-15, hours next
// - Result at most 9999h 59m 59s
// - Error on non-BCD or over 35,999,999
// - Error when word pairs straddle data areas
// - Zero flag follows zero time result
// - Error on nonexistent indirect memory operand
// - No action while execution condition off
// - Each ASCII byte becomes one hex digit
// - Up to four bytes from S..S+2 in order
// - Destination digits wrap to digit zero
// - Byte top bit is parity; none means zero
// - Even parity needs even one count
// - Odd parity needs odd one count
// - Only low seven bits give the value
// - Parity mismatch flags error, destination kept
// - Non-hex character flags error
// - Source words in different areas flag error
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module time_ascii_conv
   import conv_pkg::*;
#(
   parameter int ADDR_W = 6
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   // Whole block state, registered in one place
   typedef struct packed {
      conv_state_t st;
      logic op_hex;
      logic exec_on;
      logic go;
      logic [15:0] src0;
      logic [15:0] src1;
      logic [15:0] src2;
      logic [15:0] dsg;
      logic [15:0] dest;
      logic [2:0] area;
      logic [15:0] res0;
      logic [15:0] res1;
      logic err;
      logic zero;
      logic done;
      logic fin;
      logic [25:0] dvd;
      logic [11:0] rem;
      logic [4:0] cnt;
      logic aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [15:0] w_data;
      logic [1:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

   state_t s_reg;
   state_t s_next;

   // Address decode, shared by write and read paths
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      logic [5:0] o;
      o = 6'(a);
      addr_hit = (a[1:0] == 2'h0) && (o <= RES1_OFS);
   endfunction

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d, input logic [1:0] be);
      merge16 = old;
      if (be[0]) begin
         merge16[7:0] = d[7:0];
      end
      if (be[1]) begin
         merge16[15:8] = d[15:8];
      end
   endfunction

   // True when every nibble is a decimal digit
   function automatic logic is_bcd(input logic [15:0] w);
      is_bcd = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (w[i*4+:4] > BCD_MAX) begin
            is_bcd = 1'b0;
         end
      end
   endfunction

   // Four BCD digits to binary
   function automatic logic [13:0] bcd_to_bin(input logic [15:0] w);
      bcd_to_bin = 14'h0;
      for (int i = 3; i >= 0; i--) begin
         bcd_to_bin = 14'(bcd_to_bin * 14'h00a + 14'(w[i*4+:4]));
      end
   endfunction

   // Binary below 10000 to four BCD digits, shift-and-add-three
   function automatic logic [15:0] bin_to_bcd(input logic [13:0] b);
      logic [29:0] sh;
      sh = {16'h0, b};
      for (int i = 0; i < 14; i++) begin
         for (int d = 0; d < 4; d++) begin
            if (sh[14+d*4+:4] > 4'h4) begin
               sh[14+d*4+:4] = 4'(sh[14+d*4+:4] + 4'h3);
            end
         end
         sh = {sh[28:0], 1'b0};
      end
      bin_to_bcd = sh[29:14];
   endfunction

   // Value below 60 to two BCD digits
   function automatic logic [7:0] two_bcd(input logic [11:0] v);
      two_bcd = {4'(v / 12'h00a), 4'(v % 12'h00a)};
   endfunction

   // Checks made at the start of an operation
   logic dsg_ok;
   logic sth_err;
   logic hex_err;
   logic [15:0] hex_word;
   logic [26:0] sec_bin; // One spare bit so that 9999 9999 cannot wrap below the limit
   logic go_start;

   // Seconds-to-time operand checks and binary seconds count
   always_comb begin
      sec_bin = 27'(bcd_to_bin(s_reg.src1)) * 27'(DEC_SCALE) + 27'(bcd_to_bin(s_reg.src0));
      sth_err = !is_bcd(s_reg.src0) || !is_bcd(s_reg.src1) || (sec_bin > SEC_LIMIT);
      sth_err = sth_err || !s_reg.area[AREA_SRC_BIT] || !s_reg.area[AREA_RES_BIT];
      sth_err = sth_err || !s_reg.area[AREA_PTR_BIT];
   end

   // ASCII-to-hex conversion of all selected bytes at once
   always_comb begin
      logic [47:0] bytes;
      logic [7:0] ch;
      logic [3:0] val;
      logic [2:0] idx;
      logic [1:0] pos;
      logic par_bad;
      bytes = {s_reg.src2, s_reg.src1, s_reg.src0};
      ch = 8'h0;
      val = 4'h0;
      idx = 3'h0;
      pos = 2'h0;
      par_bad = 1'b0;
      hex_word = s_reg.dest;
      dsg_ok = (s_reg.dsg[3:0] <= DSG_POS_MAX) && (s_reg.dsg[7:4] <= DSG_POS_MAX)
         && (s_reg.dsg[11:8] <= DSG_HALF_MAX) && (s_reg.dsg[15:12] <= PAR_ODD);
      hex_err = !dsg_ok || !s_reg.area[AREA_SRC_BIT] || !s_reg.area[AREA_PTR_BIT];
      for (int k = 0; k < 4; k++) begin
         if (3'(k) <= 3'(s_reg.dsg[5:4])) begin
            // Consecutive bytes from the first half
            idx = 3'(3'(s_reg.dsg[8]) + 3'(k));
            ch = bytes[idx*8+:8];
            // No parity means top bit zero
            case (s_reg.dsg[15:12])
               PAR_NONE: par_bad = ch[7];
               PAR_EVEN: par_bad = ^ch;
               PAR_ODD: par_bad = ~^ch;
               default: par_bad = 1'b1;
            endcase
            // Value from low seven bits only
            if (ch[6:0] >= ASC_0 && ch[6:0] <= ASC_9) begin
               val = 4'(ch[6:0] - ASC_0);
            end else if (ch[6:0] >= ASC_A && ch[6:0] <= ASC_F) begin
               val = 4'(ch[6:0] - ASC_A + 7'(HEX_A));
            end else begin
               val = 4'h0;
               hex_err = 1'b1;
            end
            hex_err = hex_err || par_bad;
            pos = 2'(s_reg.dsg[1:0] + 2'(k));
            hex_word[pos*4+:4] = val;
         end
      end
   end

   assign go_start = s_reg.go && (s_reg.st == ST_IDLE);

   // Next-state logic for bus slave and conversion sequencer
   always_comb begin
      logic [12:0] trial;
      trial = 13'h0;
      s_next = s_reg;
      s_next.go = 1'b0;
      s_next.fin = 1'b0;
      // Capture write address and data in either order
      if (awvalid && s_reg.awready) begin
         s_next.aw_have = 1'b1;
         s_next.aw_addr = awaddr;
      end
      if (wvalid && s_reg.wready) begin
         s_next.w_have = 1'b1;
         s_next.w_data = wdata[15:0];
         s_next.w_strb = wstrb[1:0];
      end
      // Response drained by master
      if (s_reg.bvalid && bready) begin
         s_next.bvalid = 1'b0;
      end
      // Perform write once both halves are held
      if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
         s_next.aw_have = 1'b0;
         s_next.w_have = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = addr_hit(s_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         case (6'(s_reg.aw_addr))
            CTRL_OFS: begin
               if (s_reg.w_strb[0]) begin
                  s_next.go = s_reg.w_data[CTRL_GO_BIT];
                  s_next.op_hex = s_reg.w_data[CTRL_OP_BIT];
                  s_next.exec_on = s_reg.w_data[CTRL_EXEC_BIT];
               end
            end
            SRC0_OFS: s_next.src0 = merge16(s_reg.src0, s_reg.w_data, s_reg.w_strb);
            SRC1_OFS: s_next.src1 = merge16(s_reg.src1, s_reg.w_data, s_reg.w_strb);
            SRC2_OFS: s_next.src2 = merge16(s_reg.src2, s_reg.w_data, s_reg.w_strb);
            DSG_OFS: s_next.dsg = merge16(s_reg.dsg, s_reg.w_data, s_reg.w_strb);
            DEST_OFS: s_next.dest = merge16(s_reg.dest, s_reg.w_data, s_reg.w_strb);
            AREA_OFS: begin
               if (s_reg.w_strb[0]) begin
                  s_next.area = s_reg.w_data[2:0];
               end
            end
            // Status and results are read-only
            default: s_next.go = 1'b0;
         endcase
      end
      // Ready only while nothing of that channel is held
      s_next.awready = !s_next.aw_have;
      s_next.wready = !s_next.w_have;
      // Read channel: one read under way at a time
      if (s_reg.rvalid && rready) begin
         s_next.rvalid = 1'b0;
      end
      if (arvalid && s_reg.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rresp = addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
         case (6'(araddr))
            CTRL_OFS: s_next.rdata = 32'({s_reg.exec_on, s_reg.op_hex, 1'b0});
            SRC0_OFS: s_next.rdata = 32'(s_reg.src0);
            SRC1_OFS: s_next.rdata = 32'(s_reg.src1);
            SRC2_OFS: s_next.rdata = 32'(s_reg.src2);
            DSG_OFS: s_next.rdata = 32'(s_reg.dsg);
            DEST_OFS: s_next.rdata = 32'(s_reg.dest);
            AREA_OFS: s_next.rdata = 32'(s_reg.area);
            STAT_OFS: s_next.rdata = 32'({s_reg.zero, s_reg.err, s_reg.done, s_reg.st != ST_IDLE});
            RES0_OFS: s_next.rdata = 32'(s_reg.res0);
            RES1_OFS: s_next.rdata = 32'(s_reg.res1);
            default: s_next.rdata = 32'h0;
         endcase
      end
      s_next.arready = !s_next.rvalid;
      // Conversion sequencer
      case (s_reg.st)
         ST_IDLE: begin
            // Start only with execution condition on
            if (go_start && s_reg.exec_on) begin
               s_next.done = 1'b0;
               if (s_reg.op_hex) begin
                  s_next.fin = 1'b1;
                  s_next.done = 1'b1;
                  s_next.err = hex_err;
                  if (!hex_err) begin
                     s_next.res0 = hex_word;
                  end
               end else if (sth_err) begin
                  // Results left as they were
                  s_next.fin = 1'b1;
                  s_next.done = 1'b1;
                  s_next.err = 1'b1;
               end else begin
                  // Long division by 3600, one quotient bit per cycle
                  s_next.dvd = 26'(sec_bin);
                  s_next.rem = 12'h0;
                  s_next.cnt = 5'h0;
                  s_next.st = ST_DIV;
               end
            end
         end
         ST_DIV: begin
            // Split seconds into hours and remainder
            trial = {s_reg.rem, s_reg.dvd[25]};
            if (trial >= SEC_PER_HOUR) begin
               trial = 13'(trial - SEC_PER_HOUR);
            end
            s_next.rem = trial[11:0];
            s_next.dvd = {s_reg.dvd[24:0], ({s_reg.rem, s_reg.dvd[25]} >= SEC_PER_HOUR)};
            s_next.cnt = 5'(s_reg.cnt + 5'h1);
            if (s_reg.cnt == DIV_LAST) begin
               s_next.st = ST_FIN;
            end
         end
         ST_FIN: begin
            // Seconds low byte, minutes high byte
            // Remainder below 3600 keeps fields under 60
            s_next.res0 = {two_bcd(s_reg.rem / SEC_PER_MIN), two_bcd(12'(s_reg.rem % SEC_PER_MIN))};
            s_next.res1 = bin_to_bcd(s_reg.dvd[13:0]);
            s_next.zero = (s_reg.rem == 12'h0) && (s_reg.dvd == 26'h0);
            s_next.err = 1'b0;
            s_next.done = 1'b1;
            s_next.fin = 1'b1;
            s_next.st = ST_IDLE;
         end
         default: s_next.st = ST_IDLE;
      endcase
   end

   // State register, synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
         s_reg.st <= ST_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from flip-flops
   assign awready = s_reg.awready;
   assign wready = s_reg.wready;
   assign bvalid = s_reg.bvalid;
   assign bresp = s_reg.bresp;
   assign arready = s_reg.arready;
   assign rvalid = s_reg.rvalid;
   assign rdata = s_reg.rdata;
   assign rresp = s_reg.rresp;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   time_start_a: assert property (go_start && s_reg.exec_on && !s_reg.op_hex && !sth_err
      |-> ##[28:28] (s_reg.fin && !s_reg.err)) else $error("time conversion not done in 28 cycles");
   field_layout_a: assert property (s_reg.st == ST_FIN |=> (s_reg.res1[15:12] <= BCD_MAX)
      && (s_reg.res0[7:4] <= 4'h5)) else $error("time fields malformed");
   minsec_range_a: assert property (s_reg.st == ST_FIN |=> (s_reg.res0[7:0] <= MINSEC_MAX)
      && (s_reg.res0[15:8] <= MINSEC_MAX)) else $error("minutes or seconds above 59");
   bad_seconds_a: assert property (go_start && s_reg.exec_on && !s_reg.op_hex
      && (!is_bcd(s_reg.src0) || !is_bcd(s_reg.src1)) |=> s_reg.fin && s_reg.err && $stable(s_reg.res1))
      else $error("bad seconds not flagged");
   // Result-area check belongs to the time operation only
   area_check_a: assert property (go_start && s_reg.exec_on && !s_reg.op_hex && !s_reg.area[AREA_RES_BIT]
      |=> s_reg.err) else $error("area error not flagged");
   zero_flag_a: assert property (s_reg.st == ST_FIN |=> s_reg.zero == ((s_reg.res0 == WORD_RST)
      && (s_reg.res1 == WORD_RST))) else $error("zero flag wrong");
   pointer_check_a: assert property (go_start && s_reg.exec_on && !s_reg.area[AREA_PTR_BIT]
      |=> s_reg.err) else $error("pointer error not flagged");
   exec_off_a: assert property (go_start && !s_reg.exec_on |=> !s_reg.fin && $stable(s_reg.res0)
      && s_reg.st == ST_IDLE) else $error("ran with condition off");
   dest_kept_a: assert property (go_start && s_reg.exec_on && s_reg.op_hex && hex_err
      |=> s_reg.err && $stable(s_reg.res0)) else $error("destination changed on error");
   designator_a: assert property (go_start && s_reg.exec_on && s_reg.op_hex && !dsg_ok
      |=> s_reg.err) else $error("undefined designator accepted");

   time_ok_c: cover property (s_reg.st == ST_FIN ##1 !s_reg.err);
   hex_ok_c: cover property (go_start && s_reg.exec_on && s_reg.op_hex && !hex_err);
   hex_wrap_c: cover property (go_start && s_reg.op_hex && s_reg.dsg[1:0] == 2'h3 && s_reg.dsg[5:4] != 2'h0);
endmodule

/* sim/seq_master.sv */
`timescale 1ns/1ps
// Sequencer stand-in: register bus master
module seq_master (
   input wire logic aclk,
   output logic [5:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [5:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // Idle bus at time zero; answers are always taken at once
   initial begin
      awaddr = 6'h00;
      awvalid = 1'b0;
      wdata = 32'h0000_0000;
      wstrb = 4'h3;
      wvalid = 1'b0;
      bready = 1'b1;
      araddr = 6'h00;
      arvalid = 1'b0;
      rready = 1'b1;
   end

   // One write; address and data offered together, each let go when taken
   task automatic wr(input logic [5:0] a, input logic [15:0] d, output logic [1:0] r);
      logic got;
      got = 1'b0;
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // No cycle count assumed; the bench watchdog ends a hang
      while (!got) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            got = 1'b1;
         end
      end
   endtask

   // One read; data and response taken at the answering edge
   task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      logic got;
      got = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            got = 1'b1;
         end
      end
   endtask
endmodule

/* sim/time_and_ascii_conversion_unit_tb.sv */
`timescale 1ns/1ps
module time_and_ascii_conversion_unit_tb
   import conv_pkg::*;
();
   logic aclk, aresetn;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   // Expected result words and zero flag
   logic [15:0] e0, e1;
   logic zf;
   // Designators outside the defined set
   logic [15:0] bad [4] = '{16'h0004, 16'h0040, 16'h0200, 16'h3000};
   int n_fail = 0;
   int num_checks = 0;

   seq_master seq (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   time_ascii_conv #(.ADDR_W(6)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));

   // 100 MHz clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: response %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] v, input logic [1:0] er);
      seq.wr(a, v, r);
      chk_resp(r, er);
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] v, input logic [1:0] er);
      logic [31:0] x;
      seq.rd(a, x, r);
      chk_resp(r, er);
      chk_word(x, {16'h0000, v});
   endtask

   // Start an operation, then poll until idle (watchdog guards the poll)
   task automatic go(input logic op, input logic ex);
      logic [31:0] x;
      wr(CTRL_OFS, {13'h0000, ex, op, 1'b1}, RESP_OKAY);
      repeat (3) @(posedge aclk);
      do seq.rd(STAT_OFS, x, r);
      while (x[STAT_BUSY_BIT] !== 1'b0);
   endtask

   function automatic logic [15:0] bcd(input int v);
      return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction

   // Time conversion; t below zero means an error, results kept
   task automatic tim(input logic [15:0] s0, input logic [15:0] s1, input logic [2:0] ar, input int t);
      logic [15:0] m, s;
      wr(SRC0_OFS, s0, RESP_OKAY);
      wr(SRC1_OFS, s1, RESP_OKAY);
      wr(AREA_OFS, {13'h0000, ar}, RESP_OKAY);
      go(1'b0, 1'b1);
      if (t >= 0) begin
         m = bcd(t / 60 % 60);
         s = bcd(t % 60);
         e0 = {m[7:0], s[7:0]};
         e1 = bcd(t / 3600);
         zf = (t == 0);
      end
      rd(RES0_OFS, e0, RESP_OKAY);
      rd(RES1_OFS, e1, RESP_OKAY);
      rd(STAT_OFS, {12'h000, zf, t < 0, 2'b10}, RESP_OKAY);
   endtask

   // ASCII to hex; ok low means an error, destination kept
   task automatic hx(input logic [15:0] s0, input logic [15:0] s1, input logic [15:0] s2,
      input logic [15:0] dg, input logic [15:0] dst, input logic [2:0] ar, input logic ok,
      input logic [15:0] v);
      wr(SRC0_OFS, s0, RESP_OKAY);
      wr(SRC1_OFS, s1, RESP_OKAY);
      wr(SRC2_OFS, s2, RESP_OKAY);
      wr(DSG_OFS, dg, RESP_OKAY);
      wr(DEST_OFS, dst, RESP_OKAY);
      wr(AREA_OFS, {13'h0000, ar}, RESP_OKAY);
      go(1'b1, 1'b1);
      if (ok) e0 = v;
      rd(RES0_OFS, e0, RESP_OKAY);
      rd(STAT_OFS, {12'h000, zf, !ok, 2'b10}, RESP_OKAY);
   endtask

   // Watchdog: far beyond the expected run of under a thousand cycles
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      test_done();
   end

   // Main sequence
   initial begin
      aresetn = 1'b0;
      e0 = 16'h0000;
      e1 = 16'h0000;
      zf = 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // Reset values, unmapped and read-only places
      rd(STAT_OFS, 16'h0000, RESP_OKAY);
      rd(RES1_OFS, 16'h0000, RESP_OKAY);
      rd(AREA_OFS, 16'h0000, RESP_OKAY);
      rd(6'h28, 16'h0000, RESP_SLVERR);
      rd(6'h06, 16'h0000, RESP_SLVERR);
      wr(6'h28, 16'hffff, RESP_SLVERR);
      wr(RES0_OFS, 16'hffff, RESP_OKAY);
      rd(RES0_OFS, 16'h0000, RESP_OKAY);
      $display("test registers done");
      // Seconds to hours, minutes, seconds
      tim(16'h3661, 16'h0000, 3'h7, 3661);
      tim(16'h9999, 16'h3599, 3'h7, 35999999);
      tim(16'h0000, 16'h3600, 3'h7, -1);
      tim(16'h9999, 16'h9999, 3'h7, -1);
      tim(16'h0000, 16'h00f0, 3'h7, -1);
      tim(16'h00a0, 16'h0000, 3'h7, -1);
      tim(16'h0000, 16'h0000, 3'h7, 0);
      tim(16'h0001, 16'h0000, 3'h6, -1);
      tim(16'h0001, 16'h0000, 3'h5, -1);
      tim(16'h0001, 16'h0000, 3'h3, -1);
      tim(16'h0059, 16'h0000, 3'h7, 59);
      $display("test time done");
      // ASCII to hex
      hx(16'h4100, 16'h3942, 16'h0046, 16'h0130, 16'h1234, 3'h7, 1'b1, 16'hf9ba);
      hx(16'hb100, 16'h0036, 16'h0000, 16'h1113, 16'habcd, 3'h7, 1'b1, 16'h1bc6);
      hx(16'h0031, 16'h0000, 16'h0000, 16'h2000, 16'habcd, 3'h7, 1'b1, 16'habc1);
      hx(16'h0031, 16'h0000, 16'h0000, 16'h1000, 16'h0000, 3'h7, 1'b0, 16'h0000);
      hx(16'h0061, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 3'h7, 1'b0, 16'h0000);
      hx(16'h003a, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 3'h7, 1'b0, 16'h0000);
      hx(16'h00b1, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 3'h7, 1'b0, 16'h0000);
      foreach (bad[i]) hx(16'h0031, 16'h0000, 16'h0000, bad[i], 16'h0000, 3'h7, 1'b0, 16'h0000);
      hx(16'h0031, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 3'h5, 1'b1, 16'hfff1);
      hx(16'h0031, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 3'h6, 1'b0, 16'h0000);
      hx(16'h0031, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 3'h3, 1'b0, 16'h0000);
      $display("test hex done");
      // Valid operands but execution condition off: nothing changes
      wr(AREA_OFS, 16'h0007, RESP_OKAY);
      go(1'b1, 1'b0);
      rd(RES0_OFS, e0, RESP_OKAY);
      rd(STAT_OFS, {12'h000, zf, 3'b110}, RESP_OKAY);
      $display("test exec off done");
      test_done();
   end
endmodule
